// file: src/wash_consts.svh
`ifndef WASH_CONSTS_SVH
`define WASH_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets (8-bit register numbers).
// ----------------------------------------------------------------------------
`define REG_TIMEZONE        8'h0D
`define REG_EPOCH_HI        8'h14
`define REG_EPOCH_LO        8'h15
`define REG_LAST_WASH_HI    8'h28
`define REG_LAST_WASH_LO    8'h29
`define REG_PUMP_POWER      8'h2A
`define REG_ENCL_TEMP       8'h2B
`define REG_ENCL_HUMID      8'h2C
`define REG_BATTERY         8'h2D
`define REG_RESERVOIR       8'h2E
`define REG_INHIBIT_TEMP    8'h30
`define REG_WASH_DURATION   8'h31
`define REG_HOUR_ONE        8'h32
`define REG_HOUR_TWO        8'h33
`define REG_HOUR_THREE      8'h34
`define REG_WASH_TRIGGER    8'h35

// ----------------------------------------------------------------------------
// Reset values and codes.
// ----------------------------------------------------------------------------
`define SLAVE_ADDR_DEFAULT  8'h2B
`define INHIBIT_TEMP_RESET  16'h0115
`define DURATION_RESET      16'h0005
`define HOUR_DISABLED       16'h0019
`define TRIGGER_CODE        16'h00FF
`define KELVIN_OFFSET_C100  17'h06AB3
`define HOURS_PER_DAY       32'h00000018
`define SECONDS_PER_HOUR    32'h00000E10

// ----------------------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS       10
`define SECOND_NS           1000000000
`define CYCLES_PER_SECOND   (`SECOND_NS / `CLK_PERIOD_NS)

`endif

// file: src/wash_pkg.sv
package wash_pkg;
    // Wash sequencer states, one-hot.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_PUMP  = 3'b010,
        ST_DONE  = 3'b100
    } wash_state_t;
endpackage : wash_pkg

// file: src/second_tick.sv
`timescale 1ns/1ns
`include "wash_consts.svh"

// ----------------------------------------------------------------------------
// One-second tick generator.
// ----------------------------------------------------------------------------
module second_tick #(
    parameter int unsigned CYCLES = `CYCLES_PER_SECOND
) (
    // Clock and reset.
    input  wire logic clk_in,
    input  wire logic rstn_in,
    // Tick output.
    output logic      tick_out
);
    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic        tick_nxt;

    // Counts cycles and pulses once each elapsed second.
    always_comb begin
        tick_nxt  = (count_r == 32'(CYCLES - 1));
        count_nxt = tick_nxt ? 32'h00000000 : count_r + 32'h00000001;
    end

    // Registers the counter and the pulse.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_r  <= 32'h00000000;
            tick_out <= 1'b0;
        end else begin
            count_r  <= count_nxt;
            tick_out <= tick_nxt;
        end
    end
endmodule : second_tick

// file: src/wash_regs.sv
`timescale 1ns/1ns
`include "wash_consts.svh"
//
// Contract
// - Answers as bus slave at address 43; address not writable via registers.
// - Timezone is a 16-bit two's complement hour offset.
// - Timezone persists across power loss in non-volatile storage.
// - Writable 32-bit epoch seconds at registers 20-21, advancing each second.
// - Epoch time is volatile and lost at power removal.
// - Registers 40-41 read the epoch captured at the last wash.
// - Register 42 reads last-wash pump power in watts times 100.
// - Register 43 reads signed enclosure temperature, Celsius times 100.
// - Register 44 reads enclosure humidity, percent times 100.
// - Register 45 reads battery voltage, volts times 100.
// - Register 46 reads reservoir level: 0 water present, 3 absent.
// - Washing inhibited below kelvin limit in register 48, default 277.
// - Pump runs for register-49 seconds per wash, default 5.
// - Registers 50-52 hold wash hours; 25 disables; kept non-volatile.
// - Writing 255 to register 53 starts a wash, then clears to 0.

module wash_regs
    import wash_pkg::*;
#(
    parameter int unsigned CYCLES_PER_SEC = `CYCLES_PER_SECOND
) (
    // Clock and reset.
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    // Register port from the frame decoder.
    input  wire logic [7:0]  slave_addr_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [15:0] reg_wdata_in,
    output logic [15:0]      reg_rdata_out,
    output logic             reg_ack_out,
    // Non-volatile image, loaded at power-up, saved on change.
    input  wire logic        nv_valid_in,
    input  wire logic [15:0] nv_timezone_in,
    input  wire logic [15:0] nv_hour_one_in,
    input  wire logic [15:0] nv_hour_two_in,
    input  wire logic [15:0] nv_hour_three_in,
    output logic             nv_save_out,
    // Sensors (asynchronous to this clock).
    input  wire logic [15:0] pump_power_in,
    input  wire logic [15:0] encl_temp_in,
    input  wire logic [15:0] encl_humid_in,
    input  wire logic [15:0] battery_in,
    input  wire logic [15:0] reservoir_in,
    // Pump drive.
    output logic             pump_on_out
);
    // ------------------------------------------------------------------------
    // Sensor synchronisers.
    // ------------------------------------------------------------------------
    logic [15:0] sens_s1_r [5];
    logic [15:0] sens_s2_r [5];
    logic [15:0] sens_raw  [5];
    assign sens_raw[0] = pump_power_in;
    assign sens_raw[1] = encl_temp_in;
    assign sens_raw[2] = encl_humid_in;
    assign sens_raw[3] = battery_in;
    assign sens_raw[4] = reservoir_in;

    // Two-stage capture of every sensor word.
    genvar g;
    for (g = 0; g < 5; g++) begin : g_sync
        always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                sens_s1_r[g] <= 16'h0000;
                sens_s2_r[g] <= 16'h0000;
            end else begin
                sens_s1_r[g] <= sens_raw[g];
                sens_s2_r[g] <= sens_s1_r[g];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Second tick.
    // ------------------------------------------------------------------------
    logic tick;
    second_tick #(.CYCLES(CYCLES_PER_SEC)) u_tick (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .tick_out (tick)
    );

    // ------------------------------------------------------------------------
    // Register state.
    // ------------------------------------------------------------------------
    logic [15:0] tz_r, tz_nxt;
    logic [31:0] epoch_r, epoch_nxt;
    logic [31:0] last_wash_r, last_wash_nxt;
    logic [15:0] inhibit_r, inhibit_nxt;
    logic [15:0] dur_r, dur_nxt;
    logic [15:0] hour_r [3];
    logic [15:0] hour_nxt [3];
    logic [15:0] trig_r, trig_nxt;
    logic        loaded_r, loaded_nxt;
    logic        save_nxt;
    logic [15:0] rdata_nxt;
    logic        ack_nxt;
    logic        sel;
    logic        wr;

    // Address match on the fixed slave address.
    assign sel = (slave_addr_in == `SLAVE_ADDR_DEFAULT);
    assign wr  = sel && reg_wr_in;

    // ------------------------------------------------------------------------
    // Scheduler and wash sequencer.
    // ------------------------------------------------------------------------
    wash_state_t state_r, state_nxt;
    logic [15:0] secs_r, secs_nxt;
    logic [4:0]  last_hour_r, last_hour_nxt;
    logic        pump_nxt;
    logic [4:0]  local_hour;
    logic        inhibited;
    logic        slot_hit;
    logic        start;
    logic        launch;

    // Local hour from epoch plus signed timezone, wrapped into 0..23.
    function automatic logic [4:0] local_hour_of(input logic [31:0] ep, input logic [15:0] tz);
        logic signed [33:0] hrs;
        hrs = $signed({2'b00, ep / `SECONDS_PER_HOUR}) + $signed({{18{tz[15]}}, tz});
        hrs = hrs % $signed({2'b00, `HOURS_PER_DAY});
        if (hrs < 0) hrs = hrs + $signed({2'b00, `HOURS_PER_DAY});
        return 5'(hrs);
    endfunction : local_hour_of

    // Slot compare; 25 or any value out of 0..23 never matches.
    function automatic logic slot_match(input logic [15:0] h, input logic [4:0] lh);
        return (h < 16'h0018) && (h[4:0] == lh);
    endfunction : slot_match

    assign local_hour = local_hour_of(epoch_r, tz_r);
    // Temperature in C*100 shifted to K*100 and compared against kelvin limit times 100.
    assign inhibited  = ($signed({sens_s2_r[1][15], sens_s2_r[1]}) + $signed(`KELVIN_OFFSET_C100))
                        < $signed({1'b0, inhibit_r} * 17'd100);
    assign slot_hit   = slot_match(hour_r[0], local_hour) || slot_match(hour_r[1], local_hour)
                        || slot_match(hour_r[2], local_hour);
    // A new hour that matches starts one wash; the same hour does not retrigger.
    // A cold enclosure blocks the immediate and the scheduled wash alike.
    assign start = !inhibited && ((trig_r == `TRIGGER_CODE) ||
                   (slot_hit && (local_hour != last_hour_r)));
    // A wash is launched only from idle and with a nonzero duration.
    assign launch = (state_r == ST_IDLE) && start && (dur_r != 16'h0000);

    // Next state of the sequencer.
    always_comb begin
        state_nxt     = state_r;
        secs_nxt      = secs_r;
        pump_nxt      = 1'b0;
        last_hour_nxt = local_hour;
        last_wash_nxt = last_wash_r;
        case (state_r)
            ST_IDLE: begin
                if (launch) begin
                    state_nxt     = ST_PUMP;
                    secs_nxt      = dur_r;
                    pump_nxt      = 1'b1;
                    last_wash_nxt = epoch_r;
                end
            end
            ST_PUMP: begin
                pump_nxt = 1'b1;
                if (tick) begin
                    secs_nxt = secs_r - 16'h0001;
                    if (secs_r == 16'h0001) begin
                        state_nxt = ST_DONE;
                        pump_nxt  = 1'b0;
                    end
                end
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Registers the sequencer.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r     <= ST_IDLE;
            secs_r      <= 16'h0000;
            pump_on_out <= 1'b0;
            last_hour_r <= 5'h1F;
            last_wash_r <= 32'h00000000;
        end else begin
            state_r     <= state_nxt;
            secs_r      <= secs_nxt;
            pump_on_out <= pump_nxt;
            last_hour_r <= last_hour_nxt;
            last_wash_r <= last_wash_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Register writes, epoch counting and non-volatile load.
    // ------------------------------------------------------------------------
    always_comb begin
        tz_nxt      = tz_r;
        epoch_nxt   = tick ? epoch_r + 32'h00000001 : epoch_r;
        inhibit_nxt = inhibit_r;
        dur_nxt     = dur_r;
        hour_nxt    = hour_r;
        trig_nxt    = trig_r;
        loaded_nxt  = loaded_r;
        save_nxt    = 1'b0;
        // Trigger clears itself once the wash has been taken.
        if (launch && (trig_r == `TRIGGER_CODE)) begin
            trig_nxt = 16'h0000;
        end
        // Stored values restored once after power-up.
        if (!loaded_r && nv_valid_in) begin
            tz_nxt      = nv_timezone_in;
            hour_nxt[0] = nv_hour_one_in;
            hour_nxt[1] = nv_hour_two_in;
            hour_nxt[2] = nv_hour_three_in;
            loaded_nxt  = 1'b1;
        end
        if (wr) begin
            case (reg_addr_in)
                `REG_TIMEZONE: begin
                    tz_nxt   = reg_wdata_in;
                    save_nxt = 1'b1;
                end
                `REG_EPOCH_HI:      epoch_nxt[31:16] = reg_wdata_in;
                `REG_EPOCH_LO:      epoch_nxt[15:0]  = reg_wdata_in;
                `REG_INHIBIT_TEMP:  inhibit_nxt      = reg_wdata_in;
                `REG_WASH_DURATION: dur_nxt          = reg_wdata_in;
                `REG_HOUR_ONE: begin
                    hour_nxt[0] = reg_wdata_in;
                    save_nxt    = 1'b1;
                end
                `REG_HOUR_TWO: begin
                    hour_nxt[1] = reg_wdata_in;
                    save_nxt    = 1'b1;
                end
                `REG_HOUR_THREE: begin
                    hour_nxt[2] = reg_wdata_in;
                    save_nxt    = 1'b1;
                end
                `REG_WASH_TRIGGER:  trig_nxt = reg_wdata_in;
                default: begin
                end
            endcase
        end
    end

    // Registers the configuration.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tz_r        <= 16'h0000;
            epoch_r     <= 32'h00000000;
            inhibit_r   <= `INHIBIT_TEMP_RESET;
            dur_r       <= `DURATION_RESET;
            hour_r[0]   <= `HOUR_DISABLED;
            hour_r[1]   <= `HOUR_DISABLED;
            hour_r[2]   <= `HOUR_DISABLED;
            trig_r      <= 16'h0000;
            loaded_r    <= 1'b0;
            nv_save_out <= 1'b0;
        end else begin
            tz_r        <= tz_nxt;
            epoch_r     <= epoch_nxt;
            inhibit_r   <= inhibit_nxt;
            dur_r       <= dur_nxt;
            hour_r      <= hour_nxt;
            trig_r      <= trig_nxt;
            loaded_r    <= loaded_nxt;
            nv_save_out <= save_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Read path; unmapped registers read zero.
    // ------------------------------------------------------------------------
    always_comb begin
        ack_nxt = sel && (reg_rd_in || reg_wr_in);
        case (reg_addr_in)
            `REG_TIMEZONE:      rdata_nxt = tz_r;
            `REG_EPOCH_HI:      rdata_nxt = epoch_r[31:16];
            `REG_EPOCH_LO:      rdata_nxt = epoch_r[15:0];
            `REG_LAST_WASH_HI:  rdata_nxt = last_wash_r[31:16];
            `REG_LAST_WASH_LO:  rdata_nxt = last_wash_r[15:0];
            `REG_PUMP_POWER:    rdata_nxt = sens_s2_r[0];
            `REG_ENCL_TEMP:     rdata_nxt = sens_s2_r[1];
            `REG_ENCL_HUMID:    rdata_nxt = sens_s2_r[2];
            `REG_BATTERY:       rdata_nxt = sens_s2_r[3];
            `REG_RESERVOIR:     rdata_nxt = sens_s2_r[4];
            `REG_INHIBIT_TEMP:  rdata_nxt = inhibit_r;
            `REG_WASH_DURATION: rdata_nxt = dur_r;
            `REG_HOUR_ONE:      rdata_nxt = hour_r[0];
            `REG_HOUR_TWO:      rdata_nxt = hour_r[1];
            `REG_HOUR_THREE:    rdata_nxt = hour_r[2];
            `REG_WASH_TRIGGER:  rdata_nxt = trig_r;
            default:            rdata_nxt = 16'h0000;
        endcase
        if (!(sel && reg_rd_in)) rdata_nxt = 16'h0000;
    end

    // Registers the read answer.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 16'h0000;
            reg_ack_out   <= 1'b0;
        end else begin
            reg_rdata_out <= rdata_nxt;
            reg_ack_out   <= ack_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------------
    a_foreign_addr_ignored: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!sel && reg_rd_in) |=> (reg_ack_out == 1'b0)) else $error("foreign address answered");
    a_epoch_advances: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (tick && !wr) |=> (epoch_r == $past(epoch_r) + 32'h00000001)) else $error("epoch not advanced");
    a_epoch_hi_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr && reg_addr_in == `REG_EPOCH_HI) |=> (epoch_r[31:16] == $past(reg_wdata_in)))
        else $error("epoch high word wrong");
    a_trigger_clears: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (trig_r == `TRIGGER_CODE && state_r == ST_IDLE && dur_r != 16'h0000 && !wr && !inhibited)
        |=> (pump_on_out && trig_r == 16'h0000)) else $error("trigger did not start wash");
    a_last_wash_capture: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == ST_IDLE && state_nxt == ST_PUMP) |=> (last_wash_r == $past(epoch_r)))
        else $error("last wash time not captured");
    a_pump_runs: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == ST_PUMP && secs_r != 16'h0000) |-> pump_on_out) else $error("pump off during wash");
    a_inhibit_blocks: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state_r == ST_IDLE && inhibited) |=> !pump_on_out)
        else $error("wash while inhibited");
    a_disabled_slot: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (hour_r[0] == `HOUR_DISABLED && hour_r[1] == `HOUR_DISABLED && hour_r[2] == `HOUR_DISABLED)
        |-> !slot_hit) else $error("disabled slot matched");
    a_sensor_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (sel && reg_rd_in && reg_addr_in == `REG_ENCL_TEMP) |=> (reg_rdata_out == $past(sens_s2_r[1])))
        else $error("temperature read wrong");
endmodule : wash_regs

// file: tb/scada_master.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------------------
// Polling bus master that stands in for the supervisory system.
// ----------------------------------------------------------------------------
module scada_master (
    // Clock.
    input  wire logic        clk_in,
    // Answer from the register bank.
    input  wire logic        ack_in,
    input  wire logic [15:0] rdata_in,
    // Request lines.
    output logic [7:0]       slave_addr_out,
    output logic [7:0]       reg_addr_out,
    output logic             wr_out,
    output logic             rd_out,
    output logic [15:0]      wdata_out
);
    // Idle lines at time zero.
    initial begin
        slave_addr_out = 8'h00;
        reg_addr_out   = 8'h00;
        wr_out         = 1'b0;
        rd_out         = 1'b0;
        wdata_out      = 16'h0000;
    end

    // One transfer: a one-cycle strobe, the answer is taken in the following cycle.
    task automatic xfer(input logic wr, input logic [7:0] sa, input logic [7:0] ra,
                        input logic [15:0] wd, output logic ack, output logic [15:0] rd);
        @(negedge clk_in);
        slave_addr_out = sa;
        reg_addr_out   = ra;
        wdata_out      = wd;
        wr_out         = wr;
        rd_out         = !wr;
        @(negedge clk_in);
        wr_out         = 1'b0;
        rd_out         = 1'b0;
        ack            = ack_in;
        rd             = rdata_in;
        wdata_out      = ~wd; // Released data lines never keep the last value.
        reg_addr_out   = ~ra;
    endtask : xfer
endmodule : scada_master

// file: tb/test_wash_scheduler_register_map.sv
`timescale 1ns/1ns
`include "wash_consts.svh"

// ----------------------------------------------------------------------------
// Self-checking bench for the wash scheduler register bank.
// ----------------------------------------------------------------------------
module test_wash_scheduler_register_map;
    localparam int unsigned CPS = 10;
    logic        clk_in, rstn_in, reg_wr_in, reg_rd_in, reg_ack_out, nv_valid_in, nv_save_out, pump_on_out;
    logic [7:0]  slave_addr_in, reg_addr_in;
    logic [15:0] reg_wdata_in, reg_rdata_out, nv_timezone_in, nv_hour_in;
    logic [15:0] sens [5];
    int          fail_count, checked, cycles, saves;

    // Design and bus master.
    wash_regs #(.CYCLES_PER_SEC(CPS)) DUT (.clk_in(clk_in), .rstn_in(rstn_in), .slave_addr_in(slave_addr_in),
        .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out), .nv_valid_in(nv_valid_in),
        .nv_timezone_in(nv_timezone_in), .nv_hour_one_in(nv_hour_in), .nv_hour_two_in(nv_hour_in),
        .nv_hour_three_in(nv_hour_in), .nv_save_out(nv_save_out), .pump_power_in(sens[0]),
        .encl_temp_in(sens[1]), .encl_humid_in(sens[2]), .battery_in(sens[3]), .reservoir_in(sens[4]),
        .pump_on_out(pump_on_out));
    scada_master bus (.clk_in(clk_in), .ack_in(reg_ack_out), .rdata_in(reg_rdata_out),
        .slave_addr_out(slave_addr_in), .reg_addr_out(reg_addr_in), .wr_out(reg_wr_in),
        .rd_out(reg_rd_in), .wdata_out(reg_wdata_in));

    // Clock, cycle ceiling and save-pulse count.
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(negedge clk_in) begin
        cycles++;
        if (nv_save_out === 1'b1) saves++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    // ------------------------------------------------------------------------
    // Shared checks and transfers.
    // ------------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic rd16(input logic [7:0] ra, input logic [15:0] exp, input string what);
        logic        a;
        logic [15:0] d;
        bus.xfer(1'b0, `SLAVE_ADDR_DEFAULT, ra, 16'h0000, a, d);
        check({what, " ack"}, 32'h1, {31'h0, a});
        check(what, {16'h0, exp}, {16'h0, d});
    endtask : rd16
    task automatic wr16(input logic [7:0] ra, input logic [15:0] wd);
        logic        a;
        logic [15:0] d;
        bus.xfer(1'b1, `SLAVE_ADDR_DEFAULT, ra, wd, a, d);
        check("write ack", 32'h1, {31'h0, a});
    endtask : wr16
    task automatic wr32(input logic [7:0] ra, input logic [31:0] v);
        wr16(ra, v[31:16]);
        wr16(ra + 8'h01, v[15:0]);
    endtask : wr32
    task automatic pump_run(input int limit, output int wait_c, output int on_c);
        wait_c = 0;
        on_c = 0;
        while (pump_on_out !== 1'b1 && wait_c < limit) begin
            @(negedge clk_in);
            wait_c++;
        end
        while (pump_on_out === 1'b1 && on_c < 1000) begin
            @(negedge clk_in);
            on_c++;
        end
    endtask : pump_run
    task automatic in_range(input string what, input int lo, input int hi, input logic [31:0] got);
        checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            fail_count++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
        end
    endtask : in_range

    // ------------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------------
    task automatic t_reset;
        rd16(`REG_INHIBIT_TEMP, 16'h0115, "inhibit limit");
        rd16(`REG_WASH_DURATION, 16'h0005, "duration");
        for (int i = 0; i < 3; i++) rd16(`REG_HOUR_ONE + i[7:0], 16'h0019, "hour slot");
        rd16(`REG_WASH_TRIGGER, 16'h0000, "trigger");
        nv_valid_in = 1'b1;
        repeat (3) @(negedge clk_in);
        rd16(`REG_TIMEZONE, 16'h0003, "stored timezone");
        rd16(`REG_HOUR_THREE, 16'h0014, "stored hour slot");
    endtask : t_reset
    task automatic t_address;
        logic        a;
        logic [15:0] d;
        bus.xfer(1'b1, 8'h2A, `REG_WASH_DURATION, 16'h0007, a, d);
        check("foreign write ack", 32'h0, {31'h0, a});
        bus.xfer(1'b0, 8'h2A, `REG_WASH_DURATION, 16'h0000, a, d);
        check("foreign read ack", 32'h0, {31'h0, a});
        rd16(`REG_WASH_DURATION, 16'h0005, "duration after foreign write");
        rd16(8'h47, 16'h0000, "unmapped");
    endtask : t_address
    task automatic t_timezone;
        int s0;
        s0 = saves;
        wr16(`REG_TIMEZONE, 16'hFFF9);
        rd16(`REG_TIMEZONE, 16'hFFF9, "timezone");
        check("save pulses", 32'h1, saves - s0);
    endtask : t_timezone
    task automatic t_sensors;
        sens = '{16'h1B58, 16'h09C4, 16'h1388, 16'h04EC, 16'h0003};
        repeat (4) @(negedge clk_in);
        for (int i = 0; i < 5; i++) rd16(`REG_PUMP_POWER + i[7:0], sens[i], "sensor");
        wr16(`REG_ENCL_TEMP, 16'h1234);
        rd16(`REG_ENCL_TEMP, 16'h09C4, "read-only temperature");
    endtask : t_sensors
    task automatic t_epoch;
        logic        a;
        logic [15:0] d;
        wr32(`REG_EPOCH_HI, 32'h12345678);
        repeat (3 * CPS) @(negedge clk_in);
        rd16(`REG_EPOCH_HI, 16'h1234, "epoch high");
        bus.xfer(1'b0, `SLAVE_ADDR_DEFAULT, `REG_EPOCH_LO, 16'h0000, a, d);
        check("epoch low ack", 32'h1, {31'h0, a});
        in_range("epoch seconds", 'h567B, 'h567C, {16'h0, d});
    endtask : t_epoch
    task automatic t_wash_now;
        int          w, o;
        logic        a;
        logic [15:0] d;
        wr16(`REG_WASH_DURATION, 16'h0002);
        wr32(`REG_EPOCH_HI, 32'h00010000);
        wr16(`REG_WASH_TRIGGER, 16'h00FF);
        pump_run(5, w, o);
        in_range("pump seconds", CPS, 2 * CPS + 2, o);
        rd16(`REG_WASH_TRIGGER, 16'h0000, "trigger cleared");
        rd16(`REG_LAST_WASH_HI, 16'h0001, "last wash high");
        bus.xfer(1'b0, `SLAVE_ADDR_DEFAULT, `REG_LAST_WASH_LO, 16'h0000, a, d);
        check("last wash low ack", 32'h1, {31'h0, a});
        in_range("last wash low", 0, 1, {16'h0, d});
    endtask : t_wash_now
    task automatic t_inhibit;
        int w, o;
        sens[1] = 16'h0180;
        repeat (4) @(negedge clk_in);
        wr16(`REG_WASH_TRIGGER, 16'h00FF);
        pump_run(40, w, o);
        check("pump while cold", 32'h0, o);
        wr16(`REG_WASH_TRIGGER, 16'h0000);
        sens[1] = 16'h09C4;
    endtask : t_inhibit
    task automatic t_schedule;
        int w, o;
        wr32(`REG_EPOCH_HI, 32'h0000A8BE);
        wr16(`REG_HOUR_TWO, 16'h0005);
        pump_run(5 * CPS, w, o);
        in_range("scheduled pump", CPS, 2 * CPS + 2, o);
        pump_run(3 * CPS, w, o);
        check("second scheduled pump", 32'h0, o);
    endtask : t_schedule

    // Verdict and end of run.
    task automatic test_done;
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done

    // Main sequence.
    initial begin
        rstn_in        = 1'b0;
        nv_valid_in    = 1'b0;
        nv_timezone_in = 16'h0003;
        nv_hour_in     = 16'h0014;
        sens           = '{16'h0000, 16'h09C4, 16'h0000, 16'h0000, 16'h0000};
        repeat (10) @(negedge clk_in);
        rstn_in = 1'b1;
        t_reset();
        t_address();
        t_timezone();
        t_sensors();
        t_epoch();
        t_wash_now();
        t_inhibit();
        t_schedule();
        test_done();
    end
endmodule : test_wash_scheduler_register_map
